// ### sim/dmcc_channel_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// channel control checker
// ----------------------------------------
module dmcc_channel_sva (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // software side
  input wire channel_start_i,
  input wire resume_i,
  input wire [1:0] irq_mask_status_i,
  input wire irq_pending_rd_i,
  input wire channel_on_bit_o,
  input wire paused_flag_o,
  input wire [1:0] irq_pending_status_o,
  input wire irq_o,
  // bus and handshake
  input wire src_ack_o,
  input wire rd_req_o,
  input wire [31:0] rd_addr_o,
  input wire rd_ack_i,
  input wire wr_req_o,
  input wire [31:0] wr_addr_o,
  input wire [31:0] wr_data_o,
  input wire wr_ack_i
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  a_irq_masked_or: assert property (
    irq_o == |(irq_pending_status_o & irq_mask_status_i)) else $error("irq mismatch");
  a_start_turns_on: assert property (
    channel_start_i && !channel_on_bit_o |=> channel_on_bit_o) else $error("start lost");
  a_rd_req_held: assert property (
    rd_req_o && !rd_ack_i |=> rd_req_o && $stable(rd_addr_o)) else $error("read dropped");
  a_wr_req_held: assert property (
    wr_req_o && !wr_ack_i |=> wr_req_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write dropped");
  a_src_ack_cause: assert property (
    src_ack_o |-> $past(rd_req_o) && $past(rd_ack_i)) else $error("ack without beat");
  a_off_bus_idle: assert property (
    !channel_on_bit_o |-> !rd_req_o && !wr_req_o) else $error("bus busy while off");
  a_chain_end_off: assert property (
    $rose(irq_pending_status_o[1]) |-> ##[0:2] !channel_on_bit_o) else $error("still on");
  a_pause_needs_mask: assert property (
    $rose(paused_flag_o) |-> irq_mask_status_i[0] && irq_pending_status_o[0])
    else $error("stall without mask");
  a_pause_holds: assert property (
    paused_flag_o && !resume_i |=> paused_flag_o && !rd_req_o) else $error("stall left");
  a_read_clears: assert property (
    irq_pending_rd_i && !channel_on_bit_o |=> irq_pending_status_o == 2'h0)
    else $error("pending kept");
  // main scenarios reached
  c_stall: cover property ($rose(paused_flag_o));
  c_chain: cover property ($rose(irq_pending_status_o[1]));
  c_src_ack: cover property (src_ack_o);
endmodule
bind dmcc_channel dmcc_channel_sva dmcc_channel_sva_inst (.*);

// ### sim/dmcc_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// memory and peripheral partner
// ----------------------------------------
module dmcc_mem (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // pacing and source peripheral
  input wire slow_i,
  input wire per_on_i,
  input wire [3:0] per_line_i,
  input wire src_ack_i,
  output wire [15:0] hw_single_req_o,
  output wire [15:0] hw_chunk_req_o,
  // read port
  input wire rd_req_i,
  input wire [31:0] rd_addr_i,
  output reg rd_ack_o = 1'b0,
  output reg [31:0] rd_data_o = 32'h0000_0000,
  // write port
  input wire wr_req_i,
  input wire [31:0] wr_addr_i,
  input wire [31:0] wr_data_i,
  input wire [1:0] wr_layer_i,
  output reg wr_ack_o = 1'b0
);
  reg [31:0] mem [0:63];
  reg [1:0] lay [0:63];
  reg [1:0] wait_r = 2'h0;
  reg gap_r = 1'b0;
  integer n_rd = 0;
  integer n_wr = 0;
  // request held until acked, then dropped one cycle like a real peripheral
  assign hw_chunk_req_o = (per_on_i && !gap_r) ? (16'h0001 << per_line_i) : 16'h0000;
  assign hw_single_req_o = 16'h0000;
  // one answer at a time; slow mode waits three cycles per word
  always @(posedge clock_i) begin
    rd_ack_o <= 1'b0;
    wr_ack_o <= 1'b0;
    gap_r <= src_ack_i;
    rd_data_o <= ~rd_data_o; // idle bus inverts each cycle, so a stale word shows only every other cycle
    if (!nrst_i) begin
      wait_r <= 2'h0;
    end else if ((rd_req_i || wr_req_i) && wait_r != {slow_i, slow_i}) begin
      wait_r <= wait_r + 2'h1;
    end else if (rd_req_i && !rd_ack_o) begin
      rd_ack_o <= 1'b1;
      rd_data_o <= mem[rd_addr_i[7:2]];
      n_rd <= n_rd + 1;
      wait_r <= 2'h0;
    end else if (wr_req_i && !wr_ack_o) begin
      wr_ack_o <= 1'b1;
      mem[wr_addr_i[7:2]] <= wr_data_i;
      lay[wr_addr_i[7:2]] <= wr_layer_i;
      n_wr <= n_wr + 1;
      wait_r <= 2'h0;
    end
  end
endmodule

// ### sim/tb_dmcc_channel.sv
`timescale 1ns/1ps
module tb_dmcc_channel;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  reg clock_i = 1'b0;
  reg nrst_i = 1'b0;
  reg global_on_i = 1'b1;
  reg channel_start_i = 1'b0;
  reg resume_i = 1'b0;
  reg irq_pending_rd_i = 1'b0;
  reg [5:0] reg_wr_i = 6'h00;
  reg [31:0] reg_wdata_i = 32'h0000_0000;
  reg [1:0] irq_mask_status_i = 2'h0;
  reg [3:0] sw_req_set_i = 4'h0;
  reg slow = 1'b0;
  reg per_on = 1'b0;
  reg [3:0] per_line = 4'h3;
  wire channel_on_bit_o, paused_flag_o, irq_o, src_ack_o, dst_ack_o;
  wire rd_req_o, rd_ack_i, wr_req_o, wr_ack_i;
  wire [1:0] irq_pending_status_o, rd_layer_o, wr_layer_o;
  wire [3:0] sw_req_status_o;
  wire [15:0] hw_single_req_i, hw_chunk_req_i;
  wire [31:0] control_word_a_o, next_descriptor_ptr_o, rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
  integer err_total = 0;
  integer n_compared = 0;
  integer n_sack = 0;
  integer n_dack = 0;
  reg [1:0] rlay = 2'h0;
  integer i, k, r0, w0, s0, d0;
  reg [31:0] rows [0:3];

  dmcc_channel dmcc_channel_inst (.*);
  dmcc_mem dmcc_mem_inst (.clock_i(clock_i), .nrst_i(nrst_i), .slow_i(slow), .per_on_i(per_on),
    .per_line_i(per_line), .src_ack_i(src_ack_o), .hw_single_req_o(hw_single_req_i),
    .hw_chunk_req_o(hw_chunk_req_i), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
    .rd_ack_o(rd_ack_i), .rd_data_o(rd_data_i), .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o),
    .wr_data_i(wr_data_o), .wr_layer_i(wr_layer_o), .wr_ack_o(wr_ack_i));

  // ----------------------------------------
  // clock, counters, helpers
  // ----------------------------------------
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  // acks counted here so scenarios only compare deltas
  always @(posedge clock_i) begin
    if (src_ack_o === 1'b1) n_sack <= n_sack + 1;
    if (dst_ack_o === 1'b1) n_dack <= n_dack + 1;
    // layer seen on the ctrl b fetch of the first descriptor
    if (rd_ack_i === 1'b1 && rd_addr_o == 32'hD1) rlay <= rd_layer_o;
  end
  function [31:0] m(input integer a);
    m = dmcc_mem_inst.mem[a];
  endfunction
  task chk(input [95:0] got, input [95:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [2:0] r, input [31:0] d);
    begin
      @(posedge clock_i);
      reg_wr_i <= 6'h01 << r;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_wr_i <= 6'h00;
    end
  endtask
  // bits: start, resume, pending read
  task pulse(input [2:0] w);
    begin
      @(posedge clock_i);
      {channel_start_i, resume_i, irq_pending_rd_i} <= w;
      @(posedge clock_i);
      {channel_start_i, resume_i, irq_pending_rd_i} <= 3'h0;
    end
  endtask
  task prog(input [31:0] s, input [31:0] d, input [31:0] p, input [31:0] a, input [31:0] b,
            input [31:0] c);
    begin
      wreg(3'h0, s);
      wreg(3'h1, d);
      wreg(3'h2, p);
      wreg(3'h3, a);
      wreg(3'h4, b);
      wreg(3'h5, c);
    end
  endtask
  // bounded wait for the end of a transfer or a stall
  task settle;
    integer n;
    begin
      n = 0;
      @(negedge clock_i);
      while (channel_on_bit_o === 1'b1 && paused_flag_o !== 1'b1 && n < 3000) begin
        @(negedge clock_i);
        n = n + 1;
      end
      if (n >= 3000) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t transfer did not settle", $time);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #320000;
    err_total = err_total + 1;
    wrap_up;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    for (k = 0; k < 64; k = k + 1) dmcc_mem_inst.mem[k] = 32'h5A00_0000 + k;
    // rows: mask [21:20], expected irq [16], length [15:0]
    rows[0] = 32'h0011_0001;
    rows[1] = 32'h0000_0004;
    rows[2] = 32'h0021_0005;
    rows[3] = 32'h0031_0008;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    // single memory to memory buffers, increasing length
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clock_i);
      irq_mask_status_i <= rows[i][21:20];
      chk(channel_on_bit_o, 1'b0);
      prog(32'h40, 32'h80, 32'h0, rows[i], 32'h0060_0000, 32'h0);
      pulse(3'h4);
      settle;
      for (k = 0; k < rows[i][3:0]; k = k + 1) chk(m(32 + k), 32'h5A00_0010 + k);
      chk(m(32 + rows[i][3:0]), 32'h5A00_0020 + rows[i][3:0]);
      chk({irq_pending_status_o, irq_o, channel_on_bit_o}, {2'h3, rows[i][16], 1'b0});
      pulse(3'h1);
      @(negedge clock_i);
      chk(irq_pending_status_o, 2'h0);
      $display("row %0d done", i);
    end
    // two chained descriptors, slow memory, junk in channel registers
    dmcc_mem_inst.mem[48] = 32'h40;
    dmcc_mem_inst.mem[49] = 32'h0;
    dmcc_mem_inst.mem[50] = 32'hE0;
    dmcc_mem_inst.mem[51] = 32'h2;
    dmcc_mem_inst.mem[52] = 32'h0060_0000;
    dmcc_mem_inst.mem[56] = 32'h50;
    dmcc_mem_inst.mem[57] = 32'h8;
    dmcc_mem_inst.mem[58] = 32'h0;
    dmcc_mem_inst.mem[59] = 32'h1;
    dmcc_mem_inst.mem[60] = 32'h0060_0000;
    @(posedge clock_i);
    irq_mask_status_i <= 2'h0;
    slow <= 1'b1;
    r0 = dmcc_mem_inst.n_rd;
    prog(32'hFFFF_FFF0, 32'hFFFF_FFF0, 32'hC1, 32'hFF, 32'h8000_0000, 32'h0);
    pulse(3'h4);
    settle;
    chk(dmcc_mem_inst.n_rd - r0, 32'd13);
    chk({m(0), m(1), m(2)}, {32'h5A00_0010, 32'h5A00_0011, 32'h5A00_0014});
    chk(m(51), 32'h8000_0002);
    chk(m(59), 32'h8000_0001);
    chk({dmcc_mem_inst.lay[51], dmcc_mem_inst.lay[59]}, 4'h4);
    chk({irq_pending_status_o, channel_on_bit_o, next_descriptor_ptr_o}, {3'h6, 32'h0});
    chk({control_word_a_o, 30'h0, rlay}, {32'h8000_0001, 32'h1});
    pulse(3'h1);
    $display("chain done");
    // reload mode with stall, last buffer set by clearing reload
    @(posedge clock_i);
    slow <= 1'b0;
    irq_mask_status_i <= 2'h1;
    w0 = dmcc_mem_inst.n_wr;
    prog(32'h40, 32'hA0, 32'h0, 32'h2, 32'h8060_0000, 32'h1100);
    pulse(3'h4);
    settle;
    chk({paused_flag_o, channel_on_bit_o, irq_pending_status_o, irq_o}, 5'h1B);
    wreg(3'h4, 32'h0060_0000);
    pulse(3'h2);
    settle;
    chk(dmcc_mem_inst.n_wr - w0, 32'd4);
    chk({m(40), m(41), m(42)}, {32'h5A00_0010, 32'h5A00_0011, 32'h5A00_002A});
    chk({irq_pending_status_o, channel_on_bit_o}, 3'h6);
    pulse(3'h1);
    $display("reload done");
    // hardware source on line 3: global off, wrong line, then right line
    @(posedge clock_i);
    global_on_i <= 1'b0;
    per_on <= 1'b1;
    r0 = dmcc_mem_inst.n_rd;
    s0 = n_sack;
    d0 = n_dack;
    prog(32'h40, 32'h60, 32'h0, 32'h5, 32'h0040_0000, 32'h0203);
    pulse(3'h4);
    repeat (20) @(negedge clock_i);
    chk(dmcc_mem_inst.n_rd - r0, 32'd0);
    @(posedge clock_i);
    global_on_i <= 1'b1;
    per_line <= 4'h5;
    repeat (20) @(negedge clock_i);
    chk(dmcc_mem_inst.n_rd - r0, 32'd0);
    @(posedge clock_i);
    per_line <= 4'h3;
    settle;
    chk(n_sack - s0, 32'd2);
    chk(n_dack - d0, 32'd2);
    for (k = 0; k < 5; k = k + 1) chk(m(24 + k), 32'h5A00_0010 + k);
    pulse(3'h1);
    // software source request while the hardware line stays raised
    r0 = dmcc_mem_inst.n_rd;
    prog(32'h40, 32'h78, 32'h0, 32'h1, 32'h0040_0000, 32'h0);
    pulse(3'h4);
    repeat (20) @(negedge clock_i);
    chk(dmcc_mem_inst.n_rd - r0, 32'd0);
    @(posedge clock_i);
    sw_req_set_i <= 4'h1;
    @(posedge clock_i);
    sw_req_set_i <= 4'h0;
    settle;
    chk({m(30), sw_req_status_o, channel_on_bit_o}, {32'h5A00_0010, 5'h0});
    $display("handshake done");
    // reset in mid transfer
    @(posedge clock_i);
    slow <= 1'b1;
    prog(32'h40, 32'h80, 32'h0, 32'h8, 32'h0060_0000, 32'h0);
    pulse(3'h4);
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk({channel_on_bit_o, paused_flag_o, irq_pending_status_o, rd_req_o, wr_req_o}, 6'h0);
    @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    chk({channel_on_bit_o, rd_req_o, wr_req_o, irq_o}, 4'h0);
    $display("reset done");
    wrap_up;
  end
endmodule

// ### verilog/dmcc_channel.v
// Overview of operation
// - buffer done sets buffer interrupt, seen on irq when its mask bit is 1
// - buffer done only after last destination write is acknowledged
// - chain end sets chain interrupt, seen on irq when its mask bit is 1
// - after each buffer, pointer zero and reload off means transfer ends
// - pointer zero with reload on repeats buffers until software clears reload
// - mode is chosen only from pointer, control words and config
// - reading pending status clears it; software reads before a new transfer
// - handshake select 1 uses hardware lines, 0 uses software request bits
// - hardware handshake uses the request line chosen by the line fields
// - start write enables channel; new transactions start only while global on set
// - each single or chunk transaction completion returns an acknowledge
// - final buffer sets interrupts and clears the channel on bit
// - non-zero pointer at start fetches first descriptor into channel registers
// - after chained buffer, control word a written back on descriptor layer
// - only length count and completion flag change; done set at finish
// - unmasked buffer interrupt after a non-final buffer stalls channel until resume bit written
// - reload mode restores initial control word a, and each address whose reload bit is set, for the next buffer
// - non-zero pointer starts a chained transfer, fetched fields overwrite
`timescale 1ns/1ps
`include "dmcc_map.vh"

// ----------------------------------------
// data fifo
// ----------------------------------------
module dmcc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // flush between buffers
  input wire flush_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] count_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o = mem[rptr_r];

  // storage has no reset, only pointers and fill level do
  always @(posedge clock_i) begin
    if (push) begin
      mem[wptr_r] <= in_data_i;
    end
  end

  // pointers and fill level
  always @(posedge clock_i) begin
    if (!nrst_i || flush_i) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ----------------------------------------
// channel control
// ----------------------------------------
module dmcc_channel (
  // clock and reset
  input wire clock_i,
  input wire nrst_i,
  // software side
  input wire global_on_i,
  input wire channel_start_i,
  input wire resume_i,
  input wire [5:0] reg_wr_i,
  input wire [31:0] reg_wdata_i,
  input wire [1:0] irq_mask_status_i,
  input wire irq_pending_rd_i,
  input wire [3:0] sw_req_set_i,
  // software side status
  output wire channel_on_bit_o,
  output wire paused_flag_o,
  output wire [1:0] irq_pending_status_o,
  output wire irq_o,
  output wire [3:0] sw_req_status_o,
  output wire [31:0] control_word_a_o,
  output wire [31:0] next_descriptor_ptr_o,
  // peripheral handshake
  input wire [15:0] hw_single_req_i,
  input wire [15:0] hw_chunk_req_i,
  output wire src_ack_o,
  output wire dst_ack_o,
  // memory read master
  output wire rd_req_o,
  output wire [31:0] rd_addr_o,
  output wire [1:0] rd_layer_o,
  input wire rd_ack_i,
  input wire [31:0] rd_data_i,
  // memory write master
  output wire wr_req_o,
  output wire [31:0] wr_addr_o,
  output wire [31:0] wr_data_o,
  output wire [1:0] wr_layer_o,
  input wire wr_ack_i
);
  localparam ST_IDLE = 6'h01;
  localparam ST_FETCH = 6'h02;
  localparam ST_XFER = 6'h04;
  localparam ST_WBACK = 6'h08;
  localparam ST_EVAL = 6'h10;
  localparam ST_STALL = 6'h20;

  // request line picked from a line field
  function pick_line;
    input [15:0] lines;
    input [3:0] idx;
    begin
      pick_line = lines[idx];
    end
  endfunction

  // beats for a new transaction, capped by what remains
  function [15:0] beats;
    input chunk;
    input [15:0] remain;
    reg [15:0] want;
    begin
      want = chunk ? `DMCC_CHUNK_BEATS : `DMCC_SINGLE_BEATS;
      beats = (remain < want) ? remain : want;
    end
  endfunction

  reg [5:0] state_r;
  reg [31:0] src_r, dst_r, dscr_r, ctrla_r, ctrlb_r, cfg_r;
  reg [31:0] init_src_r, init_dst_r, init_ctrla_r, cur_desc_r;
  reg [2:0] fidx_r;
  reg chained_r, on_r, src_ack_r, dst_ack_r, s_chunk_r, d_chunk_r;
  reg [15:0] s_cnt_r, d_cnt_r, s_left_r, d_left_r;
  reg [1:0] pend_r;
  reg [3:0] swreq_r;

  wire [15:0] len = ctrla_r[`DMCC_CA_LEN_HI:0];
  wire auto_on = ctrlb_r[`DMCC_CB_AUTO];
  wire row_single = (dscr_r == `DMCC_RST_WORD) && !auto_on;
  wire stall_on = irq_mask_status_i[0];
  wire src_hs = cfg_r[`DMCC_CFG_SRC_HS];
  wire dst_hs = cfg_r[`DMCC_CFG_DST_HS];
  wire [3:0] src_line = cfg_r[`DMCC_CFG_SRC_LINE_LO+3:`DMCC_CFG_SRC_LINE_LO];
  wire [3:0] dst_line = cfg_r[`DMCC_CFG_DST_LINE_LO+3:`DMCC_CFG_DST_LINE_LO];

  // request sources per side
  wire s_sgl = src_hs ? pick_line(hw_single_req_i, src_line) : swreq_r[0];
  wire s_chk = src_hs ? pick_line(hw_chunk_req_i, src_line) : swreq_r[1];
  wire d_sgl = dst_hs ? pick_line(hw_single_req_i, dst_line) : swreq_r[2];
  wire d_chk = dst_hs ? pick_line(hw_chunk_req_i, dst_line) : swreq_r[3];
  wire s_mem = ctrlb_r[`DMCC_CB_SRC_MEM];
  wire d_mem = ctrlb_r[`DMCC_CB_DST_MEM];

  wire in_xfer = state_r == ST_XFER;
  wire run = in_xfer && global_on_i;
  wire s_go = run && s_left_r == `DMCC_RST_CNT && s_cnt_r < len && (s_mem || s_sgl || s_chk);
  wire d_go = run && d_left_r == `DMCC_RST_CNT && d_cnt_r < len && (d_mem || d_sgl || d_chk);
  wire s_chunk_new = s_mem || s_chk;
  wire d_chunk_new = d_mem || d_chk;
  wire fifo_in_ready, fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire s_beat = in_xfer && s_left_r != `DMCC_RST_CNT && fifo_in_ready;
  wire d_beat = in_xfer && d_left_r != `DMCC_RST_CNT && fifo_out_valid;
  wire buf_done = in_xfer && d_cnt_r == len && d_left_r == `DMCC_RST_CNT;
  wire evt_buf = state_r == ST_EVAL;
  wire evt_chain = evt_buf && row_single;

  // memory ports; reads serve descriptors and the source side
  assign rd_req_o = (state_r == ST_FETCH) || s_beat;
  assign rd_addr_o = (state_r == ST_FETCH) ? cur_desc_r + {27'h0, fidx_r, 2'h0} : src_r;
  assign rd_layer_o = (state_r == ST_FETCH) ? cur_desc_r[`DMCC_DSCR_LAYER_HI:0] : 2'h0;
  assign wr_req_o = (state_r == ST_WBACK) || d_beat;
  assign wr_addr_o = (state_r == ST_WBACK) ? cur_desc_r + `DMCC_DESC_CTRLA_OFS : dst_r;
  assign wr_data_o = (state_r == ST_WBACK) ? ctrla_r : fifo_out_data;
  assign wr_layer_o = (state_r == ST_WBACK) ? cur_desc_r[`DMCC_DSCR_LAYER_HI:0] : 2'h0;

  // status outputs
  assign channel_on_bit_o = on_r;
  assign paused_flag_o = state_r == ST_STALL;
  assign irq_pending_status_o = pend_r;
  assign irq_o = |(pend_r & irq_mask_status_i);
  assign sw_req_status_o = swreq_r;
  assign control_word_a_o = ctrla_r;
  assign next_descriptor_ptr_o = dscr_r;
  assign src_ack_o = src_ack_r;
  assign dst_ack_o = dst_ack_r;

  dmcc_fifo #(.WIDTH(32), .DEPTH(8), .AW(3)) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(s_beat && rd_ack_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rd_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(d_beat && wr_ack_i),
    .out_data_o(fifo_out_data),
    .flush_i(state_r == ST_EVAL)
  );

  // pending interrupts: hardware set beats the read-clear
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      pend_r <= 2'h0;
    end else begin
      pend_r <= (irq_pending_rd_i ? 2'h0 : pend_r) | {evt_chain, evt_buf};
    end
  end

  // software request bits: cleared when their transaction completes, set wins
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      swreq_r <= 4'h0;
    end else begin
      swreq_r <= (swreq_r & ~{d_ack_clr(1'b1), d_ack_clr(1'b0), s_ack_clr(1'b1),
                 s_ack_clr(1'b0)}) | sw_req_set_i;
    end
  end

  // completion of the last beat of a source or destination transaction
  function s_ack_clr;
    input chunk;
    begin
      s_ack_clr = s_beat && rd_ack_i && s_left_r == `DMCC_SINGLE_BEATS &&
                  !src_hs && s_chunk_r == chunk;
    end
  endfunction

  function d_ack_clr;
    input chunk;
    begin
      d_ack_clr = d_beat && wr_ack_i && d_left_r == `DMCC_SINGLE_BEATS &&
                  !dst_hs && d_chunk_r == chunk;
    end
  endfunction

  // channel sequencer and channel registers
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      src_r <= `DMCC_RST_WORD;
      dst_r <= `DMCC_RST_WORD;
      dscr_r <= `DMCC_RST_WORD;
      ctrla_r <= `DMCC_RST_WORD;
      ctrlb_r <= `DMCC_RST_WORD;
      cfg_r <= `DMCC_RST_WORD;
      init_src_r <= `DMCC_RST_WORD;
      init_dst_r <= `DMCC_RST_WORD;
      init_ctrla_r <= `DMCC_RST_WORD;
      cur_desc_r <= `DMCC_RST_WORD;
      fidx_r <= 3'h0;
      chained_r <= 1'b0;
      on_r <= 1'b0;
      s_cnt_r <= `DMCC_RST_CNT;
      d_cnt_r <= `DMCC_RST_CNT;
      s_left_r <= `DMCC_RST_CNT;
      d_left_r <= `DMCC_RST_CNT;
      s_chunk_r <= 1'b0;
      d_chunk_r <= 1'b0;
      src_ack_r <= 1'b0;
      dst_ack_r <= 1'b0;
    end else begin
      src_ack_r <= 1'b0;
      dst_ack_r <= 1'b0;
      // setup writes only while idle; reload bit stays writable to end repeats
      if (state_r == ST_IDLE) begin
        if (reg_wr_i[`DMCC_SEL_SRC]) src_r <= reg_wdata_i;
        if (reg_wr_i[`DMCC_SEL_DST]) dst_r <= reg_wdata_i;
        if (reg_wr_i[`DMCC_SEL_DSCR]) dscr_r <= reg_wdata_i;
        if (reg_wr_i[`DMCC_SEL_CTRLA]) ctrla_r <= reg_wdata_i;
        if (reg_wr_i[`DMCC_SEL_CFG]) cfg_r <= reg_wdata_i;
      end
      if (reg_wr_i[`DMCC_SEL_CTRLB]) ctrlb_r <= reg_wdata_i;
      case (state_r)
        ST_IDLE: begin
          if (channel_start_i && !on_r) begin
            on_r <= 1'b1;
            init_src_r <= src_r;
            init_dst_r <= dst_r;
            init_ctrla_r <= ctrla_r;
            s_cnt_r <= `DMCC_RST_CNT;
            d_cnt_r <= `DMCC_RST_CNT;
            if (dscr_r != `DMCC_RST_WORD) begin
              cur_desc_r <= dscr_r;
              fidx_r <= 3'h0;
              state_r <= ST_FETCH;
            end else begin
              chained_r <= 1'b0;
              state_r <= ST_XFER;
            end
          end
        end
        ST_FETCH: begin
          if (rd_ack_i) begin
            // fixed word order, movement waits for all five
            case (fidx_r)
              3'h0: src_r <= rd_data_i;
              3'h1: dst_r <= rd_data_i;
              3'h2: dscr_r <= rd_data_i;
              3'h3: ctrla_r <= rd_data_i;
              default: ctrlb_r <= rd_data_i;
            endcase
            fidx_r <= fidx_r + 1'b1;
            if (fidx_r == `DMCC_DESC_WORDS - 1'b1) begin
              chained_r <= 1'b1;
              s_cnt_r <= `DMCC_RST_CNT;
              d_cnt_r <= `DMCC_RST_CNT;
              state_r <= ST_XFER;
            end
          end
        end
        ST_XFER: begin
          // source transactions into the fifo
          if (s_go) begin
            s_left_r <= beats(s_chunk_new, len - s_cnt_r);
            s_chunk_r <= s_chunk_new;
          end else if (s_beat && rd_ack_i) begin
            src_r <= src_r + `DMCC_WORD_STEP;
            s_cnt_r <= s_cnt_r + 1'b1;
            s_left_r <= s_left_r - 1'b1;
            src_ack_r <= s_left_r == `DMCC_SINGLE_BEATS;
          end
          // destination transactions out of the fifo
          if (d_go) begin
            d_left_r <= beats(d_chunk_new, len - d_cnt_r);
            d_chunk_r <= d_chunk_new;
          end else if (d_beat && wr_ack_i) begin
            dst_r <= dst_r + `DMCC_WORD_STEP;
            d_cnt_r <= d_cnt_r + 1'b1;
            d_left_r <= d_left_r - 1'b1;
            dst_ack_r <= d_left_r == `DMCC_SINGLE_BEATS;
          end
          if (buf_done) begin
            ctrla_r[`DMCC_CA_DONE] <= 1'b1;
            ctrla_r[`DMCC_CA_LEN_HI:0] <= d_cnt_r;
            state_r <= chained_r ? ST_WBACK : ST_EVAL;
          end
        end
        ST_WBACK: begin
          if (wr_ack_i) begin
            state_r <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          s_cnt_r <= `DMCC_RST_CNT;
          d_cnt_r <= `DMCC_RST_CNT;
          if (row_single) begin
            on_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            if (dscr_r == `DMCC_RST_WORD) begin
              // repeat buffer from the values first programmed
              ctrla_r <= init_ctrla_r;
              if (cfg_r[`DMCC_CFG_SRC_RELOAD]) src_r <= init_src_r;
              if (cfg_r[`DMCC_CFG_DST_RELOAD]) dst_r <= init_dst_r;
            end
            cur_desc_r <= dscr_r;
            fidx_r <= 3'h0;
            if (stall_on) begin
              state_r <= ST_STALL;
            end else begin
              state_r <= (dscr_r != `DMCC_RST_WORD) ? ST_FETCH : ST_XFER;
            end
          end
        end
        ST_STALL: begin
          // auto bit is read again at the next eval, so a clear made here ends repeats
          if (resume_i) begin
            state_r <= (cur_desc_r != `DMCC_RST_WORD) ? ST_FETCH : ST_XFER;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verilog/dmcc_map.vh
`ifndef DMCC_MAP_VH
`define DMCC_MAP_VH
// ----------------------------------------
// register select codes for reg_wr_i
// ----------------------------------------
`define DMCC_SEL_SRC 0
`define DMCC_SEL_DST 1
`define DMCC_SEL_DSCR 2
`define DMCC_SEL_CTRLA 3
`define DMCC_SEL_CTRLB 4
`define DMCC_SEL_CFG 5
// ----------------------------------------
// field positions
// ----------------------------------------
`define DMCC_CA_LEN_HI 15
`define DMCC_CA_DONE 31
`define DMCC_CB_AUTO 31
`define DMCC_CB_SRC_MEM 21
`define DMCC_CB_DST_MEM 22
`define DMCC_CFG_SRC_LINE_LO 0
`define DMCC_CFG_DST_LINE_LO 4
`define DMCC_CFG_SRC_RELOAD 8
`define DMCC_CFG_SRC_HS 9
`define DMCC_CFG_DST_RELOAD 12
`define DMCC_CFG_DST_HS 13
`define DMCC_DSCR_LAYER_HI 1
// ----------------------------------------
// descriptor layout and timing counts
// ----------------------------------------
`define DMCC_DESC_WORDS 3'h5
`define DMCC_DESC_CTRLA_OFS 32'h0000000C
`define DMCC_WORD_STEP 32'h00000004
`define DMCC_CHUNK_BEATS 16'h0004
`define DMCC_SINGLE_BEATS 16'h0001
// ----------------------------------------
// reset values
// ----------------------------------------
`define DMCC_RST_WORD 32'h00000000
`define DMCC_RST_CNT 16'h0000
`endif
